// File: verilog/exec_pkg.sv
// Purpose: shared constants and types for the three-instruction execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   register offsets are byte addresses on the register bus
package exec_pkg;

  // widths
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BSEL_W  = 3;

  // instruction fields
  localparam int unsigned OPC6_MSB = 13;
  localparam int unsigned OPC6_LSB = 8;
  localparam int unsigned OPC4_LSB = 10;
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned ADDR_MSB = 6;
  localparam int unsigned BSEL_MSB = 9;
  localparam int unsigned BSEL_LSB = 7;

  // opcodes
  localparam logic [5:0] OPC_AND  = 6'h05;
  localparam logic [5:0] OPC_ADD  = 6'h07;
  localparam logic [3:0] OPC_BCLR = 4'h4;

  // register offsets
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_ACCUM  = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_COUNT  = 8'h14;

  // flag and status bit positions
  localparam int unsigned FLG_C      = 0;
  localparam int unsigned FLG_DC     = 1;
  localparam int unsigned FLG_Z      = 2;
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_ILLEGAL = 1;
  localparam int unsigned ST_REFUSED = 2;
  localparam int unsigned ST_PH_LSB  = 8;

  // reset values
  localparam logic [DATA_W-1:0]  ACCUM_RST = 8'h00;
  localparam logic [2:0]         FLAGS_RST = 3'h0;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
  localparam logic [15:0]        COUNT_RST = 16'h0000;

  typedef enum logic [4:0] {
    PH_IDLE    = 5'b00001,
    PH_DECODE  = 5'b00010,
    PH_READ    = 5'b00100,
    PH_PROCESS = 5'b01000,
    PH_WRITE   = 5'b10000
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_AND  = 2'h1,
    OP_ADD  = 2'h2,
    OP_BCLR = 2'h3
  } op_t;

endpackage

// File: verilog/alu_if.sv
// Purpose: carries operands and results between the sequencer and the data path
// Assumes: purely combinational data path
// Notes:   none
`timescale 1ns/1ps
interface alu_if;
  import exec_pkg::*;
  op_t               op;
  logic [DATA_W-1:0] accum;
  logic [DATA_W-1:0] fval;
  logic [BSEL_W-1:0] bit_sel;
  logic [DATA_W-1:0] result;
  logic              carry;
  logic              half_carry_flag;
  logic              zero;

  modport core (output op, accum, fval, bit_sel, input result, carry, half_carry_flag, zero);
  modport alu  (input op, accum, fval, bit_sel, output result, carry, half_carry_flag, zero);
endinterface

// File: verilog/file_alu.sv
// Purpose: process-phase data path for and, add and bit clear
// Assumes: operands stable for the whole process phase
// Notes:   flags are always computed; the sequencer decides which to keep
`timescale 1ns/1ps
module file_alu (
  // operands and results
  alu_if.alu a
);
  import exec_pkg::*;

  logic [DATA_W:0]   sum;
  logic [4:0]        low_sum;
  logic [DATA_W-1:0] cleared;

  assign sum     = {1'b0, a.accum} + {1'b0, a.fval};
  assign low_sum = {1'b0, a.accum[3:0]} + {1'b0, a.fval[3:0]};

  // only the selected bit drops, every other bit passes through
  for (genvar i = 0; i < DATA_W; i++) begin : g_clr
    assign cleared[i] = (a.bit_sel == BSEL_W'(i)) ? 1'b0 : a.fval[i];
  end

  always_comb begin
    a.result          = a.fval;
    a.carry           = sum[DATA_W];
    a.half_carry_flag = low_sum[4];
    case (a.op)
      OP_AND:  a.result = a.accum & a.fval;
      OP_ADD:  a.result = sum[DATA_W-1:0];
      OP_BCLR: a.result = cleared;
      default: a.result = a.fval;
    endcase
    a.zero = (a.result == '0);
  end

endmodule

// File: verilog/and_add_bitclear_exec.sv
// Purpose: decode and execute and, add and bit clear on an accumulator and file registers
// Assumes: file storage sits outside on the same clock and answers a read in the same cycle
// Notes:   instructions are issued by writing the instruction register over the bus
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module and_add_bitclear_exec (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // register bus
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic [31:0]                         hrdata,
  // file register storage
  output logic [exec_pkg::FADDR_W-1:0]        file_addr,
  output logic                                file_rd_en,
  input  wire logic [exec_pkg::DATA_W-1:0]    file_rdata,
  output logic                                file_wr_en,
  output logic [exec_pkg::DATA_W-1:0]         file_wdata,
  // status
  output logic                                busy
);
  import exec_pkg::*;

  alu_if alu_bus ();

  file_alu u_alu (
    .a (alu_bus.alu)
  );

  // sequencer state
  phase_t             phase_ff;
  phase_t             nxt_phase;
  logic [INSTR_W-1:0] instr_ff;
  op_t                op_ff;
  op_t                nxt_op;
  logic               dest_ff;
  logic [BSEL_W-1:0]  bsel_ff;
  logic [FADDR_W-1:0] faddr_ff;
  logic [DATA_W-1:0]  fval_ff;
  logic [DATA_W-1:0]  res_ff;
  logic [2:0]         pend_flags_ff;
  logic [2:0]         flag_keep_ff;

  // architectural state
  logic [DATA_W-1:0]  accum_ff;
  logic [2:0]         flags_ff;
  logic               illegal_ff;
  logic               refused_ff;
  logic [15:0]        count_ff;

  // bus state
  logic               wr_pend_ff;
  logic               rd_wait_ff;
  logic [7:0]         dp_addr_ff;
  logic [31:0]        hrdata_ff;

  logic               addr_phase;
  logic               wr_stb;
  logic               issue;
  logic [31:0]        rd_mux;

  // bus slave: writes take no wait state, reads one
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_stb     = wr_pend_ff;
  assign hreadyout  = ~rd_wait_ff;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
    end else if (hready) begin
      wr_pend_ff <= addr_phase & hwrite;
      rd_wait_ff <= addr_phase & ~hwrite;
    end else begin
      rd_wait_ff <= 1'b0;
    end
  end

  // the data-phase address must hold through the read wait state
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_addr_ff <= 8'h00;
    end else if (addr_phase) begin
      dp_addr_ff <= haddr[7:0];
    end
  end

  // the read value is sampled one cycle into the data phase so that a write
  // in the phase before is already visible
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_addr_ff == REG_INSTR) begin
      rd_mux[INSTR_W-1:0] = instr_ff;
    end else if (dp_addr_ff == REG_ACCUM) begin
      rd_mux[DATA_W-1:0] = accum_ff;
    end else if (dp_addr_ff == REG_FLAGS) begin
      rd_mux[2:0] = flags_ff;
    end else if (dp_addr_ff == REG_STATUS) begin
      rd_mux[ST_BUSY]                 = busy;
      rd_mux[ST_ILLEGAL]              = illegal_ff;
      rd_mux[ST_REFUSED]              = refused_ff;
      rd_mux[ST_PH_LSB+4:ST_PH_LSB]   = phase_ff;
    end else if (dp_addr_ff == REG_RESULT) begin
      rd_mux[DATA_W-1:0] = res_ff;
    end else if (dp_addr_ff == REG_COUNT) begin
      rd_mux[15:0] = count_ff;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_wait_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  // issue: an instruction write while busy is dropped and flagged
  assign issue = wr_stb && (dp_addr_ff == REG_INSTR) && (phase_ff == PH_IDLE);
  assign busy  = (phase_ff != PH_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      instr_ff <= INSTR_RST;
    end else if (issue) begin
      instr_ff <= hwdata[INSTR_W-1:0];
    end
  end

  // decode, from the held instruction word; an unknown word only sets the illegal flag
  always_comb begin
    nxt_op = OP_NONE;
    if (instr_ff[OPC6_MSB:OPC6_LSB] == OPC_AND) begin
      nxt_op = OP_AND;
    end else if (instr_ff[OPC6_MSB:OPC6_LSB] == OPC_ADD) begin
      nxt_op = OP_ADD;
    end else if (instr_ff[OPC6_MSB:OPC4_LSB] == OPC_BCLR) begin
      nxt_op = OP_BCLR;
    end
  end

  // one instruction cycle of four phases
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_IDLE:    if (issue) begin
                    nxt_phase = PH_DECODE;
                  end
      PH_DECODE:  nxt_phase = (nxt_op == OP_NONE) ? PH_IDLE : PH_READ;
      PH_READ:    nxt_phase = PH_PROCESS;
      PH_PROCESS: nxt_phase = PH_WRITE;
      PH_WRITE:   nxt_phase = PH_IDLE;
      default:    nxt_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= PH_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // operand fields, latched in the decode phase
  always_ff @(posedge clk) begin
    if (rst) begin
      op_ff    <= OP_NONE;
      dest_ff  <= 1'b0;
      bsel_ff  <= '0;
      faddr_ff <= '0;
    end else if (phase_ff == PH_DECODE) begin
      op_ff    <= nxt_op;
      dest_ff  <= (nxt_op == OP_BCLR) ? 1'b1 : instr_ff[DEST_POS];
      bsel_ff  <= instr_ff[BSEL_MSB:BSEL_LSB];
      faddr_ff <= instr_ff[ADDR_MSB:0];
    end
  end

  // which flags the write phase may change; an illegal word never reaches
  // the write phase, so its mask is never used
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_keep_ff <= 3'h0;
    end else if (phase_ff == PH_DECODE) begin
      case (nxt_op)
        OP_AND:  flag_keep_ff <= 3'(1 << FLG_Z);
        OP_ADD:  flag_keep_ff <= 3'(1 << FLG_C) | 3'(1 << FLG_DC) | 3'(1 << FLG_Z);
        OP_BCLR: flag_keep_ff <= 3'h0;
        default: flag_keep_ff <= 3'h0;
      endcase
    end
  end

  // read phase: storage answers combinationally
  assign file_rd_en = (phase_ff == PH_READ);
  assign file_addr  = faddr_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      fval_ff <= '0;
    end else if (phase_ff == PH_READ) begin
      fval_ff <= file_rdata;
    end
  end

  // process phase
  assign alu_bus.op      = op_ff;
  assign alu_bus.accum   = accum_ff;
  assign alu_bus.fval    = fval_ff;
  assign alu_bus.bit_sel = bsel_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      res_ff        <= '0;
      pend_flags_ff <= FLAGS_RST;
    end else if (phase_ff == PH_PROCESS) begin
      res_ff                <= alu_bus.result;
      pend_flags_ff[FLG_C]  <= alu_bus.carry;
      pend_flags_ff[FLG_DC] <= alu_bus.half_carry_flag;
      pend_flags_ff[FLG_Z]  <= alu_bus.zero;
    end
  end

  // write phase
  assign file_wr_en = (phase_ff == PH_WRITE) && dest_ff;
  assign file_wdata = res_ff;

  // software may load the accumulator only while idle, so it never meets the write phase
  always_ff @(posedge clk) begin
    if (rst) begin
      accum_ff <= ACCUM_RST;
    end else if ((phase_ff == PH_WRITE) && !dest_ff) begin
      accum_ff <= res_ff;
    end else if (wr_stb && (dp_addr_ff == REG_ACCUM) && !busy) begin
      accum_ff <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= FLAGS_RST;
    end else if (phase_ff == PH_WRITE) begin
      // bit clear keeps all flags
      flags_ff <= (flags_ff & ~flag_keep_ff) | (pend_flags_ff & flag_keep_ff);
    end else if (wr_stb && (dp_addr_ff == REG_FLAGS) && !busy) begin
      flags_ff <= hwdata[2:0];
    end
  end

  // sticky status: a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      illegal_ff <= 1'b0;
    end else if ((phase_ff == PH_DECODE) && (nxt_op == OP_NONE)) begin
      illegal_ff <= 1'b1;
    end else if (wr_stb && (dp_addr_ff == REG_STATUS) && hwdata[ST_ILLEGAL]) begin
      illegal_ff <= 1'b0;
    end
  end

  // an issue that meets a busy sequencer is dropped, not queued: software polls busy
  always_ff @(posedge clk) begin
    if (rst) begin
      refused_ff <= 1'b0;
    end else if (wr_stb && (dp_addr_ff == REG_INSTR) && busy) begin
      refused_ff <= 1'b1;
    end else if (wr_stb && (dp_addr_ff == REG_STATUS) && hwdata[ST_REFUSED]) begin
      refused_ff <= 1'b0;
    end
  end

  // completed instructions, wraps
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= COUNT_RST;
    end else if (phase_ff == PH_WRITE) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

endmodule

// File: test/and_add_bitclear_exec_checker.sv
// Purpose: bus and phase timing checks on the execute block
// Assumes: one clock, synchronous active-high reset
// Notes:   data values are judged by the bench
`timescale 1ns/1ps
module and_add_bitclear_exec_checker (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst,
  // register bus
  input wire logic                        hsel,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  // file side
  input wire logic [exec_pkg::FADDR_W-1:0] file_addr,
  input wire logic                        file_rd_en,
  input wire logic                        file_wr_en,
  input wire logic                        busy
);
  import exec_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rq;
  assign rq = hsel && hready && htrans[1];

  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_wr_nowait; rq && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_wait; rq && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_decode_read; $rose(busy) ##1 busy |-> file_rd_en; endproperty
  a_decode_read: assert property (p_decode_read) else $error("no read after decode");
  property p_phases; $rose(file_rd_en) |-> busy [*3] ##1 !busy; endproperty
  a_phases: assert property (p_phases) else $error("phase count wrong");
  property p_rd_pulse; file_rd_en |=> !file_rd_en; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_wr_slot; file_wr_en |-> busy && $past(file_rd_en, 2); endproperty
  a_wr_slot: assert property (p_wr_slot) else $error("file write out of slot");
  property p_wr_addr; file_wr_en |-> file_addr == $past(file_addr, 2); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address moved");
  property p_quiet; !busy |-> !file_rd_en && !file_wr_en; endproperty
  a_quiet: assert property (p_quiet) else $error("file access while idle");

  c_file_wr: cover property (file_wr_en);
  c_illegal: cover property ($rose(busy) ##1 !busy);
  c_read: cover property (rq && !hwrite);
endmodule

bind and_add_bitclear_exec and_add_bitclear_exec_checker i_chk (.clk, .rst, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .file_addr, .file_rd_en, .file_wr_en, .busy);

// File: test/and_add_bitclear_exec_tb_top.sv
// Purpose: self-checking bench for the and, add and bit clear execute block
// Assumes: bench is bus master and file storage
// Notes:   expected results worked out by hand
`timescale 1ns/1ps
module and_add_bitclear_exec_tb_top;
  import exec_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        haddr = 32'h0;
  logic [31:0]        hwdata = 32'h0;
  logic [31:0]        hrdata, rd;
  logic               hreadyout, hresp, file_rd_en, file_wr_en, busy;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0]  file_wdata, file_rdata;
  logic [DATA_W-1:0]  mem [128];
  int                 n_errors = 0, cmp_count = 0, cyc = 0, n_done = 0, n;

  and_add_bitclear_exec i_and_add_bitclear_exec (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .file_addr, .file_rd_en, .file_rdata,
    .file_wr_en, .file_wdata, .busy);

  // storage answers in the same cycle
  assign file_rdata = mem[file_addr];
  always @(posedge clk) if (file_wr_en) mem[file_addr] <= file_wdata;

  initial forever #20 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // hreadyout only moves after edges, so its level at the negedge is what the next edge samples
  task automatic wait_rdy;
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    rd = hrdata;
    @(posedge clk);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    wait_rdy;
    htrans <= 2'h0;
    wait_rdy;
    chk(rd, exp);
  endtask

  task automatic idle;
    n = 0;
    @(negedge clk);
    while (busy === 1'b1) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask

  task automatic do_op(input logic [13:0] ins, input logic [7:0] a, f, r, fi, fo);
    logic k;
    k = ins[12] || ins[7];
    mem[ins[6:0]] = f;
    bus_wr(REG_ACCUM, {24'h0, a});
    bus_wr(REG_FLAGS, {24'h0, fi});
    bus_wr(REG_INSTR, {18'h0, ins});
    idle;
    chk(n, 4);
    rd_chk(REG_ACCUM, {24'h0, k ? a : r});
    chk({24'h0, mem[ins[6:0]]}, {24'h0, k ? r : f});
    rd_chk(REG_FLAGS, {24'h0, fo});
    rd_chk(REG_RESULT, {24'h0, r});
    n_done++;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    hsel <= 1'b1;
    rd_chk(REG_FLAGS, 32'h0);
    rd_chk(REG_ACCUM, 32'h0);
    rd_chk(REG_COUNT, 32'h0);
    rd_chk(REG_STATUS, 32'h100);
    rd_chk(8'h18, 32'h0);
    $display("reset test done");
    do_op(14'h0525, 8'hA3, 8'h5C, 8'h00, 8'h03, 8'h07);
    do_op(14'h05FF, 8'hF0, 8'h3C, 8'h30, 8'h07, 8'h03);
    $display("and test done");
    do_op(14'h0704, 8'h17, 8'hC2, 8'hD9, 8'h07, 8'h00);
    do_op(14'h0790, 8'h88, 8'h78, 8'h00, 8'h00, 8'h07);
    do_op(14'h0711, 8'hF0, 8'h20, 8'h10, 8'h00, 8'h01);
    do_op(14'h0722, 8'h0F, 8'h01, 8'h10, 8'h00, 8'h02);
    $display("add test done");
    for (int b = 0; b < 8; b++) begin
      do_op(14'h1033 | (14'(b) << 7), 8'h5A, 8'hFF, ~(8'h01 << b), 8'h05, 8'h05);
    end
    rd_chk(REG_COUNT, 32'(n_done));
    $display("bit clear test done");
    bus_wr(REG_INSTR, 32'h3FFF);
    idle;
    chk(n, 1);
    rd_chk(REG_STATUS, 32'h102);
    $display("illegal test done");
    mem[7'h40] = 8'h11;
    bus_wr(REG_INSTR, 32'h0740);
    // second issue lands while the add is still in flight
    bus_wr(REG_INSTR, 32'h05C0);
    idle;
    chk({24'h0, mem[7'h40]}, 32'h11);
    rd_chk(REG_ACCUM, 32'h6B);
    rd_chk(REG_STATUS, 32'h106);
    bus_wr(REG_STATUS, 32'h6);
    bus_wr(REG_RESULT, 32'h55);
    rd_chk(REG_STATUS, 32'h100);
    rd_chk(REG_RESULT, 32'h6B);
    $display("refused test done");
    give_verdict;
  end
endmodule
